// File: hdl/sdlc_cfg.svh
/*
  Constants of the serial DAC loader and chain: widths, field positions,
  reset values and FIFO depth.
  Assumes it is included by bare name wherever these values are needed.
*/
`ifndef SDLC_CFG_SVH
`define SDLC_CFG_SVH

// ==========================================================
// shift register and code field
`define SDLC_SHIFT_W 16
`define SDLC_CODE_W 10
`define SDLC_CODE_MSB 11
`define SDLC_CODE_LSB 2
`define SDLC_CODE_RST 10'h000
`define SDLC_CODE_MID 10'h200
`define SDLC_WORD_RST 16'h0000

// ==========================================================
// buffering between capture and conversion register
`define SDLC_FIFO_DEPTH 8

`endif

// File: hdl/sdlc_pkg.sv
/*
  Types shared by the serial DAC loader modules.
  Assumes sdlc_cfg.svh is reachable by bare name.
*/
`include "sdlc_cfg.svh"

package sdlc_pkg;
  // ==========================================================
  // data types
  typedef logic [`SDLC_SHIFT_W-1:0] sdlc_word_t; // full shift register word
  typedef logic [`SDLC_CODE_W-1:0] sdlc_code_t; // straight binary dac code
endpackage

// File: hdl/sdlc_stream_if.sv
/*
  Valid/ready stream carrying one dac code between loader modules.
  Assumes sdlc_pkg is compiled first; both ends share one clock.
*/
interface sdlc_stream_if;
  import sdlc_pkg::*;
  sdlc_code_t data; // code word
  logic valid; // producer holds a word
  logic ready; // consumer takes it this cycle
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// File: hdl/sdlc_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`include "sdlc_cfg.svh"
module sdlc_fifo import sdlc_pkg::*; #(
  parameter int WIDTH = `SDLC_CODE_W,
  parameter int DEPTH = `SDLC_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic sysRst,
  sdlc_stream_if.snk inPort,
  sdlc_stream_if.src outPort
);
  localparam int PW = $clog2(DEPTH);

  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH]; // word store
  logic [PW-1:0] wrPtr_r; // next slot to fill
  logic [PW-1:0] rdPtr_r; // oldest word
  logic [PW:0] count_r; // words held
  logic push; // accepted write
  logic pop; // accepted read

  function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  assign inPort.ready = (count_r != (PW + 1)'(DEPTH)); // honest full
  assign outPort.valid = (count_r != '0); // honest empty
  assign outPort.data = mem[rdPtr_r];
  assign push = inPort.valid && inPort.ready;
  assign pop = outPort.valid && outPort.ready;

  // write side
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r] <= inPort.data;
    end
  end

  // pointers
  always_ff @(posedge clock) begin
    if (sysRst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= ptrInc(wrPtr_r);
      end
      if (pop) begin
        rdPtr_r <= ptrInc(rdPtr_r);
      end
    end
  end

  // occupancy
  always_ff @(posedge clock) begin
    if (sysRst) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + (PW + 1)'(1);
    end else if (pop && !push) begin
      count_r <= count_r - (PW + 1)'(1);
    end
  end
endmodule

// File: hdl/sdlc_link.sv
/*
  Link-side logic on the shift clock: input shift register and chain output.
  Assumes the host keeps the shift clock low while select is high.
*/
`include "sdlc_cfg.svh"
module sdlc_link import sdlc_pkg::*; (
  input wire logic shiftClk,
  input wire logic sysRst,
  input wire logic selectN,
  input wire logic serialIn,
  output sdlc_word_t shiftWord,
  output logic chainOut
);
  // ==========================================================
  // reset bridge: asserts at once, releases on shift clock
  logic linkRstMeta_r; // first stage
  logic linkRst_r; // link-domain reset
  logic shiftedOut_r; // bit pushed out of the top on the last rising edge
  sdlc_word_t word_r; // input shift register

  // reset release synchroniser
  always_ff @(posedge shiftClk or posedge sysRst) begin
    if (sysRst) begin
      linkRstMeta_r <= 1'b1;
      linkRst_r <= 1'b1;
    end else begin
      linkRstMeta_r <= 1'b0;
      linkRst_r <= linkRstMeta_r;
    end
  end

  // ==========================================================
  // shift register, msb first, rising edges while selected
  always_ff @(posedge shiftClk or posedge linkRst_r) begin
    if (linkRst_r) begin
      word_r <= `SDLC_WORD_RST;
      shiftedOut_r <= 1'b0;
    end else if (!selectN) begin // R05
      word_r <= {word_r[`SDLC_SHIFT_W-2:0], serialIn}; // R02 R03
      shiftedOut_r <= word_r[`SDLC_SHIFT_W-1]; // R14
    end
  end

  // chain output: falling edges while selected, holds otherwise
  always_ff @(negedge shiftClk or posedge linkRst_r) begin
    if (linkRst_r) begin
      chainOut <= 1'b0;
    end else if (!selectN) begin
      chainOut <= shiftedOut_r; // R12 R13
    end
  end

  assign shiftWord = word_r;

  // ==========================================================
  // checks on the link clock
  property p_shift_in;
    @(posedge shiftClk) disable iff (linkRst_r)
    !selectN |=> word_r == {$past(word_r[`SDLC_SHIFT_W-2:0]), $past(serialIn)};
  endproperty
  a_shift_in: assert property (p_shift_in) // R03
    else $error("shift register did not take data in");

  property p_hold_deselected;
    @(posedge shiftClk) disable iff (linkRst_r)
    selectN |=> $stable(word_r);
  endproperty
  a_hold_deselected: assert property (p_hold_deselected) // R05
    else $error("shifted while deselected");

  property p_chain_delay;
    @(posedge shiftClk) disable iff (linkRst_r)
    (!selectN) [*8] ##1 (!selectN) [*8] ##1 (!selectN) [*2]
      |-> shiftedOut_r == $past(serialIn, 17) || $past(linkRst_r, 17);
  endproperty
  a_chain_delay: assert property (p_chain_delay) else $error("chain bit delay wrong"); // R14

  property p_chain_follow;
    @(negedge shiftClk) disable iff (linkRst_r)
    !selectN |-> ##0 1'b1 ##1 chainOut == $past(shiftedOut_r) || selectN;
  endproperty
  a_chain_follow: assert property (p_chain_follow) else $error("chain output not updated"); // R12

  c_long_frame: cover property (@(posedge shiftClk) (!selectN) [*8] ##1 (!selectN) [*8]);
endmodule

// File: hdl/sdlc_loader.sv
/*
  Top of the serial DAC loader and chain: link logic on the shift clock,
  select edge capture on the system clock, an 8-word FIFO, and the
  conversion register feeding the analog core.
  Assumes the host changes select only while the shift clock is low and
  keeps that clock low while select is high, so the shift register is
  stable whenever select is seen high in the system domain.
*/
`include "sdlc_cfg.svh"

// Overview of operation
// R01: power-up clears conversion register to zero
// R02: selected: shift 16 bits, msb first
// R03: sample input on each rising shift edge
// R04: select rising edge loads conversion register; here via the FIFO, once convAccept takes the code
// R05: deselected: shift clock edges ignored
// R06: host moves select only clock low
// R07: host holds clock low when deselected
// R08: unchained host may send 12-bit frame
// R09: or 16-bit frame, four dummy bits first
// R10: host sends two zero sub-lsb bits
// R11: code is straight binary, 0x200 midscale
// R12: chain output changes on falling edges
// R13: deselected: chain output holds last bit
// R14: chain delay sixteen cycles plus half
// R15: chained host sends 16 bits per device
// R16: host clock at most about 14 MHz
// R17: byte host sends two bytes per select
// R18: code taken from word bits 11 to 2
module sdlc_loader import sdlc_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic shiftClk,
  input wire logic selectN,
  input wire logic serialIn,
  input wire logic convAccept,
  output logic chainOut,
  output sdlc_code_t convCode_r,
  output logic convUpdate_r,
  output logic loadReady_r,
  output logic wordLost_r
);

  // ==========================================================
  // clock domains and crossings
  // the link logic runs on the shift clock and owns the shift register
  // and the chain output; everything else runs on the system clock
  // besides the reset, through the link bridge, two things cross: the select level, through two flops, and the
  // shift word, which is read once select is seen high and the host has
  // parked the shift clock low, so the word is quiet while it is read
  // a host that keeps clocking while deselected is ignored by the link,
  // so the word still stays put for the capture

  // ==========================================================
  // link side on the shift clock
  sdlc_word_t shiftWord; // link shift register, stable while deselected

  // shift register and chain output live in the link domain
  sdlc_link linkSide (
    .shiftClk(shiftClk),
    .sysRst(sys_rst),
    .selectN(selectN),
    .serialIn(serialIn),
    .shiftWord(shiftWord),
    .chainOut(chainOut)
  );

  // ==========================================================
  // select synchroniser into the system clock
  // select is the only host pin level the system clock looks at; both flops
  // reset to the deselected level so no false edge follows reset
  logic selMeta_r; // first stage, read only by the second
  logic selSync_r; // synchronised select level, high = deselected
  logic selSyncD_r; // delayed copy for edge detection
  logic selRise; // select has just gone high

  // two flops before any logic looks at select
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      selMeta_r <= 1'b1;
      selSync_r <= 1'b1;
    end else begin
      selMeta_r <= selectN;
      selSync_r <= selMeta_r;
    end
  end

  // edge detector on the synchronised level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      selSyncD_r <= 1'b1;
    end else begin
      selSyncD_r <= selSync_r;
    end
  end

  assign selRise = selSync_r && !selSyncD_r;

  // ==========================================================
  // word capture at the end of a frame
  // the captured code waits one cycle in a register and is offered to
  // the FIFO for a single cycle; if the FIFO is full the word is dropped
  // and the drop is reported, the earlier words are kept
  sdlc_stream_if capStream (); // capture into FIFO
  sdlc_stream_if convStream (); // FIFO into conversion register
  sdlc_code_t capCode_r; // code pulled from the captured word
  logic capValid_r; // capture waiting for FIFO
  sdlc_code_t convCode_nxt; // next conversion register value

  // code field of a full shift word, upper four and lower two bits only feed the chain
  function automatic sdlc_code_t codeField(input sdlc_word_t w);
    return w[`SDLC_CODE_MSB:`SDLC_CODE_LSB];
  endfunction

  // sample the stable shift word once select is seen high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      capCode_r <= `SDLC_CODE_RST;
    end else if (selRise) begin
      // the link clock is idle here, so the word is not moving
      capCode_r <= codeField(shiftWord); // R04 R18
    end
  end

  // one-cycle offer to the FIFO for each select rising edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      capValid_r <= 1'b0;
    end else begin
      capValid_r <= selRise;
    end
  end

  assign capStream.data = capCode_r;
  assign capStream.valid = capValid_r;

  // word lost when the FIFO is full at capture time
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wordLost_r <= 1'b0;
    end else begin
      wordLost_r <= capValid_r && !capStream.ready;
    end
  end

  // FIFO space shown to the system
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loadReady_r <= 1'b0;
    end else begin
      loadReady_r <= capStream.ready;
    end
  end

  // ==========================================================
  // buffering between capture and conversion register
  // up to eight codes wait here while the analog core holds accept low;
  // the ninth capture in a row without a drain is the first one lost
  sdlc_fifo #(
    .WIDTH(`SDLC_CODE_W),
    .DEPTH(`SDLC_FIFO_DEPTH)
  ) codeFifo (
    .clock(clock),
    .sysRst(sys_rst),
    .inPort(capStream.snk),
    .outPort(convStream.src)
  );

  // analog core stalls the drain by holding accept low
  assign convStream.ready = convAccept;

  // ==========================================================
  // conversion register
  // the register only moves when the core takes a word, so a dropped
  // frame never disturbs the code already on the output
  always_comb begin
    convCode_nxt = convCode_r;
    if (convStream.valid && convAccept) begin
      convCode_nxt = convStream.data; // R11
    end
  end

  // cleared on reset, so the output starts at zero code
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      convCode_r <= `SDLC_CODE_RST; // R01
    end else begin
      convCode_r <= convCode_nxt; // R04
    end
  end

  // one-cycle pulse when a new code lands
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      convUpdate_r <= 1'b0;
    end else begin
      convUpdate_r <= convStream.valid && convAccept;
    end
  end

  // ==========================================================
  // checks on the system clock
  // all of them are off during reset, except the reset checks themselves
  // reset leaves zero code and no update pulse
  property p_reset_zero;
    @(posedge clock) sys_rst |=> convCode_r == `SDLC_CODE_RST && !convUpdate_r;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R01
    else $error("conversion register not cleared");

  // the captured code is bits 11 to 2 of the word seen at the edge
  property p_capture_field;
    @(posedge clock) disable iff (sys_rst)
    selRise |=> capCode_r == $past(shiftWord[`SDLC_CODE_MSB:`SDLC_CODE_LSB]) && capValid_r;
  endproperty
  a_capture_field: assert property (p_capture_field) // R18
    else $error("wrong code field captured");

  // each synchronised select edge gives exactly one offer
  property p_edge_to_offer;
    @(posedge clock) disable iff (sys_rst)
    $rose(selSync_r) |=> capValid_r ##1 !capValid_r;
  endproperty
  a_edge_to_offer: assert property (p_edge_to_offer) // R04
    else $error("select edge not offered once");

  // an accepted word lands in the register one cycle later
  property p_update_value;
    @(posedge clock) disable iff (sys_rst)
    convStream.valid && convAccept |=> convUpdate_r && convCode_r == $past(convStream.data);
  endproperty
  a_update_value: assert property (p_update_value) // R04
    else $error("conversion register missed word");

  // without an accepted word the register and pulse stay quiet
  property p_hold_value;
    @(posedge clock) disable iff (sys_rst)
    !(convStream.valid && convAccept) |=> $stable(convCode_r) && !convUpdate_r;
  endproperty
  a_hold_value: assert property (p_hold_value) // R11
    else $error("conversion register changed alone");

  // an offer that meets a full FIFO is reported
  property p_lost_when_full;
    @(posedge clock) disable iff (sys_rst)
    capValid_r && !capStream.ready |=> wordLost_r;
  endproperty
  a_lost_when_full: assert property (p_lost_when_full) else $error("lost word not flagged"); // R04

  // with an empty FIFO and the core taking, a frame lands in three cycles
  property p_end_to_end;
    @(posedge clock) disable iff (sys_rst)
    selRise && !convStream.valid && convAccept ##1 convAccept [*2]
      |-> ##1 convCode_r == $past(codeField(shiftWord), 3);
  endproperty
  a_end_to_end: assert property (p_end_to_end) // R18
    else $error("frame code did not reach output");

  // chain output is quiet while select has been high a while
  property p_chain_hold;
    @(posedge clock) disable iff (sys_rst)
    selSync_r && selSyncD_r [*3] |-> $stable(chainOut);
  endproperty
  a_chain_hold: assert property (p_chain_hold) // R13
    else $error("chain output moved while deselected");

  // the register moves only together with its update pulse
  property p_code_on_upd;
    @(posedge clock) disable iff (sys_rst)
    $changed(convCode_r) |-> convUpdate_r;
  endproperty
  a_code_on_upd: assert property (p_code_on_upd) else $error("code moved without update"); // R01

  // an update pulse needs a waiting word that the core took
  property p_upd_accept;
    @(posedge clock) disable iff (sys_rst)
    convUpdate_r |-> $past(convAccept) && $past(convStream.valid);
  endproperty
  a_upd_accept: assert property (p_upd_accept) else $error("update without accept"); // R04

  // a word is only reported lost when the FIFO had no room
  property p_lost_full;
    @(posedge clock) disable iff (sys_rst)
    wordLost_r |-> !loadReady_r;
  endproperty
  a_lost_full: assert property (p_lost_full) else $error("lost word with room"); // R04

  // reset clears the status outputs and any pending offer
  property p_reset_flags;
    @(posedge clock) sys_rst |=> !loadReady_r && !wordLost_r && !capValid_r;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags set in reset"); // R01

  // one select edge is one pulse, never two in a row
  property p_rise_once;
    @(posedge clock) disable iff (sys_rst)
    selRise |=> !selRise;
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("select edge seen twice"); // R04

  // an offer to the FIFO always follows a select edge
  property p_offer_rise;
    @(posedge clock) disable iff (sys_rst)
    capValid_r |-> $past(selRise);
  endproperty
  a_offer_rise: assert property (p_offer_rise) else $error("offer without select edge"); // R04

  // a stalled core sees no update and an unchanged code
  property p_stall_hold;
    @(posedge clock) disable iff (sys_rst)
    !convAccept |=> !convUpdate_r && $stable(convCode_r);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("update while stalled"); // R04

  c_frame_loaded: cover property (@(posedge clock) selRise ##[1:4] convUpdate_r);
  c_fifo_full: cover property (@(posedge clock) !loadReady_r);
  c_word_lost: cover property (@(posedge clock) wordLost_r);
  c_midscale: cover property (@(posedge clock) convUpdate_r && convCode_r == `SDLC_CODE_MID);
endmodule

// File: sim/sdlc_host_model.sv
/*
  Host serial master model: drives select, shift clock and serial data,
  logs the chain output after every falling shift edge of a frame.
  Assumes a 16 ns shift clock (15 ns in the pulse task) that stands still outside frames, except in the pulse task.
*/
module sdlc_host_model (
  output logic shiftClk,
  output logic selectN,
  output logic serialIn,
  input wire logic chainOut
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // state
  logic chainLog[$]; // chain output seen after each falling edge

  // idle: deselected, clock low
  initial begin
    shiftClk = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b0;
  end

  // one frame of n bits, msb first, within one select
  task automatic send(input logic [31:0] w, input int n);
    chainLog.delete();
    selectN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = w[i];
      #7.5 shiftClk = 1'b1;
      #7.5 shiftClk = 1'b0;
      #1 chainLog.push_back(chainOut);
      if (i > 0 && i % 8 == 0) #30;
    end
    #6.5 selectN = 1'b1;
    serialIn = ~serialIn; // released line shows the inverse
    #60; // select high well beyond capture time
  endtask

  // clock pulses while deselected, data toggling
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      serialIn = ~serialIn;
      #7.5 shiftClk = 1'b1;
      #7.5 shiftClk = 1'b0;
    end
    #15;
  endtask
endmodule

// File: sim/sdlc_loader_tb_top.sv
/*
  Self-checking bench of the serial dac loader: frames, chain delay,
  deselected clocks and fifo overflow.
  Assumes sdlc_pkg, the design and sdlc_host_model are compiled first.
*/
module sdlc_loader_tb_top;
  import sdlc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic clock, sys_rst, convAccept; // system side inputs
  logic shiftClk, selectN, serialIn; // link inputs from host
  logic chainOut, convUpdate_r, loadReady_r, wordLost_r;
  sdlc_code_t convCode_r; // conversion register
  sdlc_code_t codes[$]; // codes seen at each update
  int lostCount, n_errors, check_count;

  // 200 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  sdlc_host_model host (.shiftClk(shiftClk), .selectN(selectN), .serialIn(serialIn),
    .chainOut(chainOut));

  sdlc_loader DUT (.clock(clock), .sys_rst(sys_rst), .shiftClk(shiftClk),
    .selectN(selectN), .serialIn(serialIn), .convAccept(convAccept),
    .chainOut(chainOut), .convCode_r(convCode_r), .convUpdate_r(convUpdate_r),
    .loadReady_r(loadReady_r), .wordLost_r(wordLost_r));

  // collect updates and drops
  always @(negedge clock) begin
    if (convUpdate_r === 1'b1) codes.push_back(convCode_r);
    if (wordLost_r === 1'b1) lostCount++;
  end

  // ==========================================================
  // compare, wait and closing
  task automatic check_code(input sdlc_code_t got, input sdlc_code_t exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: code %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // bounded wait for n collected codes
  task automatic wait_codes(input int n);
    for (int i = 0; i < 300 && codes.size() < n; i++) @(posedge clock);
    if (codes.size() < n) begin
      n_errors++;
      $display("unexpected at %0t: no update arrived", $time);
      end_of_test();
    end
  endtask

  task automatic set_accept(input logic v);
    @(posedge clock);
    #1 convAccept = v;
  endtask

  // send one frame and compare the resulting code
  task automatic frame_check(input logic [31:0] w, input int n, input sdlc_code_t exp);
    codes.delete();
    host.send(w, n);
    wait_codes(1);
    check_code(codes.pop_front(), exp);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    repeat (2) @(posedge clock);
    #1 check_code(convCode_r, 10'h000);
    check_bit(convUpdate_r, 1'b0);
    check_bit(chainOut, 1'b0);
    check_bit(loadReady_r, 1'b1);
    host.pulse(2);
    $display("test reset done");
  endtask

  task automatic t_frames();
    set_accept(1'b1);
    frame_check({16'h0000, 4'hA, 10'h200, 2'b00}, 16, 10'h200);
    frame_check({20'h00000, 10'h3FF, 2'b00}, 12, 10'h3FF);
    frame_check({16'h0000, 4'h5, 10'h001, 2'b00}, 16, 10'h001);
    $display("test frames done");
  endtask

  task automatic t_chain();
    logic [31:0] w;
    logic last;
    w = 32'hC35A1234;
    codes.delete();
    host.send(w, 32);
    for (int j = 1; j <= 16; j++) check_bit(host.chainLog[j + 15], w[32 - j]);
    wait_codes(1);
    check_code(codes.pop_front(), w[11:2]);
    last = host.chainLog[31];
    repeat (10) @(posedge clock);
    check_bit(chainOut, last);
    $display("test chain done");
  endtask

  task automatic t_ignore();
    logic last;
    sdlc_word_t word;
    last = chainOut;
    host.pulse(6);
    check_bit(chainOut, last);
    word = {12'h234, 4'hB};
    frame_check(32'h0000000B, 4, word[11:2]);
    $display("test ignore done");
  endtask

  task automatic t_fifo();
    set_accept(1'b0);
    codes.delete();
    lostCount = 0;
    for (int i = 1; i <= 9; i++) host.send({16'h0000, 4'h0, sdlc_code_t'(i), 2'b00}, 16);
    repeat (10) @(posedge clock);
    #1 check_bit(loadReady_r, 1'b0);
    check_bit(1'(lostCount == 1), 1'b1);
    check_bit(1'(codes.size() == 0), 1'b1);
    set_accept(1'b1);
    wait_codes(8);
    for (int i = 1; i <= 8; i++) check_code(codes.pop_front(), sdlc_code_t'(i));
    repeat (4) @(posedge clock);
    #1 check_bit(loadReady_r, 1'b1);
    $display("test fifo done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    convAccept = 1'b0;
    lostCount = 0;
    n_errors = 0;
    check_count = 0;
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    t_reset();
    t_frames();
    t_chain();
    t_ignore();
    t_fifo();
    end_of_test();
  end
endmodule
